// *** rtl/sfrel_defs.svh ***
`ifndef SFREL_DEFS_SVH
`define SFREL_DEFS_SVH

// register byte offsets
`define SFREL_OFS_CTRL     12'h000
`define SFREL_OFS_STAT     12'h004
`define SFREL_OFS_LAST     12'h008

// exception bit positions, shared by flags, masks and status
`define SFREL_FLG_IE       0
`define SFREL_FLG_DE       1
`define SFREL_FLG_ZE       2
`define SFREL_FLG_OE       3
`define SFREL_FLG_UNF      4
`define SFREL_FLG_INX      5

// control register fields
`define SFREL_CTRL_FLG_LO  0
`define SFREL_CTRL_DAZ     6
`define SFREL_CTRL_MSK_LO  7
`define SFREL_CTRL_RC_LO   13
`define SFREL_CTRL_RST     32'h00001F80
`define SFREL_CTRL_WMASK   32'h00007FFF

// status register fields
`define SFREL_STAT_TRAP    6

// trap reporting
`define SFREL_TRAP_VEC     8'h13

// exponent range, bias and trap scaling
`define SFREL_EMIN         12'shF82
`define SFREL_EMAX         12'sh07F
`define SFREL_BIAS         12'sh07F
`define SFREL_SCALE        12'sh0C0
`define SFREL_SH_MAX       12'sh030

// result magnitudes
`define SFREL_MAG_MAXF     31'h7F7FFFFF
`define SFREL_MAG_INF      31'h7F800000

`endif

// *** rtl/sfrel_pkg.sv ***
package sfrel_pkg;

    typedef enum logic [1:0] {
        SFREL_RND_NEAR = 2'h0,
        SFREL_RND_DOWN = 2'h1,
        SFREL_RND_UP   = 2'h2,
        SFREL_RND_ZERO = 2'h3
    } sfrel_rnd_t;

endpackage : sfrel_pkg

// *** rtl/sfrel_round.sv ***
`timescale 1ns/100ps
`default_nettype none

// one rounding step straight from the exact significand; the shift denormalizes
module sfrel_round (
    input  wire logic                  sign,
    input  wire logic [47:0]           sig,
    input  wire logic [5:0]            shift,
    input  wire sfrel_pkg::sfrel_rnd_t mode,
    output logic      [24:0]           rounded,
    output logic                       inexact
);
    logic [95:0] wide;
    logic [23:0] kept;
    logic        guard;
    logic        sticky;
    logic        up;

    // 48 zero pad bits keep every bit shifted out by up to 48 places inside sticky
    assign wide   = {sig, 48'h000000000000} >> shift;
    assign kept   = wide[95:72];
    assign guard  = wide[71];
    assign sticky = |wide[70:0];

    always_comb begin
        unique case (mode)
            sfrel_pkg::SFREL_RND_NEAR: up = guard & (sticky | kept[0]);
            sfrel_pkg::SFREL_RND_DOWN: up = sign & (guard | sticky);
            sfrel_pkg::SFREL_RND_UP:   up = ~sign & (guard | sticky);
            sfrel_pkg::SFREL_RND_ZERO: up = 1'b0;
        endcase
    end

    assign rounded = {1'b0, kept} + {24'h000000, up};
    assign inexact = guard | sticky;

endmodule : sfrel_round
`default_nettype wire

// *** rtl/sfrel_top.sv ***
// Functional notes
// - masked overflow sets overflow and inexact; nearest gives signed infinity.
// - masked overflow: round down/up give largest finite or infinity by sign; toward zero gives largest finite.
// - unmasked overflow delivers unbounded rounded result over two to 192.
// - tiny after unbounded rounding; masked gives bounded result, flags if inexact.
// - unmasked underflow delivers unbounded rounded result times two to 192.
// - inexact results set inexact; masked, bounded rounded result is returned.
// - unmasked inexact traps with masked under/overflow results or bounded result.
// - unmasked exceptions are reported on interrupt vector 19.
// - with denormals-as-zeros set, denormal operands become signed zeros, flags untouched.
// - invalid, denormal, divide-by-zero first; unmasked ones skip size checks.
// - tiny results shift right until exponent reaches -126, by at most 48 places.
// - denormalized results are rounded once, from the exact value.
// - flag and mask bits: invalid, denormal, zero-divide, overflow, underflow, inexact.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "sfrel_defs.svh"

module sfrel_top (
    input  wire logic                CLK,
    input  wire logic                ARST_N,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [11:0]         PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic                     PREADY,
    output logic      [31:0]         PRDATA,
    output logic                     PSLVERR,
    input  wire logic [31:0]         OPND_A,
    input  wire logic [31:0]         OPND_B,
    output logic      [31:0]         OPND_A_DAZ,
    output logic      [31:0]         OPND_B_DAZ,
    input  wire logic                RES_VALID,
    input  wire logic                RES_SIGN,
    input  wire logic signed [11:0]  RES_EXP,
    input  wire logic [47:0]         RES_SIG,
    input  wire logic [2:0]          RES_PRE_FLAGS,
    input  wire logic                RES_SPECIAL,
    input  wire logic [31:0]         RES_SPECIAL_VAL,
    output logic                     RESULT_VALID,
    output logic      [31:0]         RESULT,
    output logic                     RESULT_WE,
    output logic      [5:0]          RESULT_FLAGS,
    output logic                     EXC_TRAP,
    output logic      [7:0]          EXC_VECTOR
);
    logic [31:0]             ctrl_reg;
    logic [31:0]             stat_reg;
    logic [31:0]             last_reg;
    logic                    in_valid_reg;
    logic                    in_sign_reg;
    logic signed [11:0]      in_exp_reg;
    logic [47:0]             in_sig_reg;
    logic [2:0]              in_pre_reg;
    logic                    in_special_reg;
    logic [31:0]             in_special_val_reg;
    logic [5:0]              msk;
    sfrel_pkg::sfrel_rnd_t   mode;
    logic [24:0]             ru;
    logic [24:0]             rb;
    logic                    inx_u;
    logic                    inx_b;
    logic signed [11:0]      exp_u;
    logic signed [11:0]      under_by;
    logic [5:0]              sh_b;
    logic                    huge;
    logic                    tiny;
    logic [31:0]             res_u_up;
    logic [31:0]             res_u_dn;
    logic [31:0]             res_b;
    logic [31:0]             res_next;
    logic [5:0]              flg_next;
    logic                    trap_next;
    logic                    wr_en;
    logic                    setup;

    function automatic logic [31:0] daz(input logic [31:0] v, input logic on);
        daz = (on && v[30:23] == 8'h00) ? {v[31], 31'h00000000} : v;
    endfunction : daz

    function automatic logic [31:0] ovf_res(input logic s, input sfrel_pkg::sfrel_rnd_t m);
        logic big;
        big = 1'b1;
        unique case (m)
            sfrel_pkg::SFREL_RND_NEAR: big = 1'b1;
            sfrel_pkg::SFREL_RND_DOWN: big = s;
            sfrel_pkg::SFREL_RND_UP:   big = ~s;
            sfrel_pkg::SFREL_RND_ZERO: big = 1'b0;
        endcase
        ovf_res = {s, big ? `SFREL_MAG_INF : `SFREL_MAG_MAXF};
    endfunction : ovf_res

    function automatic logic [31:0] pack(input logic s, input logic signed [11:0] e,
                                         input logic [24:0] r);
        pack = r[24] ? {s, e[7:0], r[23:1]} : {s, e[7:0], r[22:0]};
    endfunction : pack

    // one decode for the error response; the read mux lists the same offsets
    function automatic logic reg_mapped(input logic [11:0] a);
        reg_mapped = (a == `SFREL_OFS_CTRL) || (a == `SFREL_OFS_STAT) || (a == `SFREL_OFS_LAST);
    endfunction : reg_mapped

    // masks share the flag order, a one means masked
    assign msk  = ctrl_reg[`SFREL_CTRL_MSK_LO +: 6];
    assign mode = sfrel_pkg::sfrel_rnd_t'(ctrl_reg[`SFREL_CTRL_RC_LO +: 2]);

    // operand conditioning ahead of the arithmetic; the denormal flag is not touched here
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            OPND_A_DAZ <= 32'h00000000;
            OPND_B_DAZ <= 32'h00000000;
        end else begin
            OPND_A_DAZ <= daz(OPND_A, ctrl_reg[`SFREL_CTRL_DAZ]);
            OPND_B_DAZ <= daz(OPND_B, ctrl_reg[`SFREL_CTRL_DAZ]);
        end
    end

    // capture the exact result; breaks the path from the pipeline into the rounders
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            in_valid_reg       <= 1'b0;
            in_sign_reg        <= 1'b0;
            in_exp_reg         <= 12'sh000;
            in_sig_reg         <= 48'h000000000000;
            in_pre_reg         <= 3'h0;
            in_special_reg     <= 1'b0;
            in_special_val_reg <= 32'h00000000;
        end else begin
            in_valid_reg       <= RES_VALID;
            in_sign_reg        <= RES_SIGN;
            in_exp_reg         <= RES_EXP;
            in_sig_reg         <= RES_SIG;
            in_pre_reg         <= RES_PRE_FLAGS;
            in_special_reg     <= RES_SPECIAL;
            in_special_val_reg <= RES_SPECIAL_VAL;
        end
    end

    // unbounded exponent rounding, used for tininess and the trap handler result
    sfrel_round u_round_unb (
        .sign    (in_sign_reg),
        .sig     (in_sig_reg),
        .shift   (6'h00),
        .mode    (mode),
        .rounded (ru),
        .inexact (inx_u)
    );

    // bounded rounding works on the exact value again, not on ru
    assign under_by = `SFREL_EMIN - in_exp_reg;
    always_comb begin
        if (in_exp_reg >= `SFREL_EMIN) begin
            sh_b = 6'h00;
        end else if (under_by > `SFREL_SH_MAX) begin
            sh_b = 6'(`SFREL_SH_MAX);
        end else begin
            sh_b = under_by[5:0];
        end
    end

    sfrel_round u_round_bnd (
        .sign    (in_sign_reg),
        .sig     (in_sig_reg),
        .shift   (sh_b),
        .mode    (mode),
        .rounded (rb),
        .inexact (inx_b)
    );

    // size checks use the exponent after rounding, so a carry past the top counts as huge
    assign exp_u    = in_exp_reg + $signed({11'h000, ru[24]});
    assign huge     = exp_u > `SFREL_EMAX;
    assign tiny     = exp_u < `SFREL_EMIN;
    // scaled trap results wrap in the exponent field; the handler gets no range check
    assign res_u_dn = pack(in_sign_reg, exp_u - `SFREL_SCALE + `SFREL_BIAS, {1'b0, ru[24] ? ru[24:1] : ru[23:0]});
    assign res_u_up = pack(in_sign_reg, exp_u + `SFREL_SCALE + `SFREL_BIAS, {1'b0, ru[24] ? ru[24:1] : ru[23:0]});

    // a denormalized value carries exponent field 0, or 1 if rounding reached the normal range
    always_comb begin
        if (sh_b == 6'h00) begin
            // same input and shift as the unbounded rounder, so exp_u already holds the carry
            res_b = pack(in_sign_reg, exp_u + `SFREL_BIAS, rb);
        end else begin
            res_b = {in_sign_reg, 7'h00, rb[23], rb[22:0]};
        end
    end

    always_comb begin
        res_next  = 32'h00000000;
        flg_next  = {3'h0, in_pre_reg};
        trap_next = 1'b0;
        if (|(in_pre_reg & ~msk[2:0])) begin
            trap_next = 1'b1;
        end else if (in_special_reg) begin
            res_next = in_special_val_reg;
        end else if (huge) begin
            flg_next[`SFREL_FLG_OE] = 1'b1;
            if (msk[`SFREL_FLG_OE]) begin
                res_next                 = ovf_res(in_sign_reg, mode);
                flg_next[`SFREL_FLG_INX] = 1'b1;
            end else begin
                res_next                 = res_u_dn;
                flg_next[`SFREL_FLG_INX] = inx_u;
                trap_next                = 1'b1;
            end
        end else if (tiny && !msk[`SFREL_FLG_UNF]) begin
            res_next                 = res_u_up;
            flg_next[`SFREL_FLG_UNF] = 1'b1;
            flg_next[`SFREL_FLG_INX] = inx_u;
            trap_next                = 1'b1;
        end else begin
            res_next                 = res_b;
            flg_next[`SFREL_FLG_INX] = inx_b;
            flg_next[`SFREL_FLG_UNF] = tiny & inx_b;
        end
        // inexact traps only once under/overflow have been dealt with as masked
        if (flg_next[`SFREL_FLG_INX] && !msk[`SFREL_FLG_INX]) begin
            trap_next = 1'b1;
        end
    end

    // results leave two cycles after RES_VALID; a trapped result goes to the handler only
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RESULT_VALID <= 1'b0;
            RESULT       <= 32'h00000000;
            RESULT_WE    <= 1'b0;
            RESULT_FLAGS <= 6'h00;
            EXC_TRAP     <= 1'b0;
            EXC_VECTOR   <= 8'h00;
        end else begin
            RESULT_VALID <= in_valid_reg;
            RESULT       <= in_valid_reg ? res_next : 32'h00000000;
            RESULT_WE    <= in_valid_reg & ~trap_next;
            RESULT_FLAGS <= in_valid_reg ? flg_next : 6'h00;
            EXC_TRAP     <= in_valid_reg & trap_next;
            EXC_VECTOR   <= (in_valid_reg & trap_next) ? `SFREL_TRAP_VEC : 8'h00;
        end
    end

    // apb slave: one wait-free access, pready raised for the access phase
    assign setup = PSEL & ~PENABLE;
    assign wr_en = PSEL & PENABLE & PREADY & PWRITE;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= setup;
            PSLVERR <= setup & ~reg_mapped(PADDR);
        end
    end

    // read data is zero outside the access phase so a stale word never looks valid
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PRDATA <= 32'h00000000;
        end else if (setup && !PWRITE) begin
            unique case (PADDR)
                `SFREL_OFS_CTRL: PRDATA <= ctrl_reg;
                `SFREL_OFS_STAT: PRDATA <= stat_reg;
                `SFREL_OFS_LAST: PRDATA <= last_reg;
                default:         PRDATA <= 32'h00000000;
            endcase
        end else begin
            PRDATA <= 32'h00000000;
        end
    end

    // sticky flags: a flag raised by a result in the same cycle as a write survives it
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_reg <= `SFREL_CTRL_RST;
        end else begin
            ctrl_reg <= ((wr_en && PADDR == `SFREL_OFS_CTRL) ? (PWDATA & `SFREL_CTRL_WMASK) : ctrl_reg)
                        | (in_valid_reg ? {26'h0000000, flg_next} : 32'h00000000);
        end
    end

    // status and last result follow every result, trapped ones too, for the handler
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stat_reg <= 32'h00000000;
        end else if (in_valid_reg) begin
            stat_reg <= {25'h0000000, trap_next, flg_next};
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            last_reg <= 32'h00000000;
        end else if (in_valid_reg) begin
            last_reg <= res_next;
        end
    end

endmodule : sfrel_top
`default_nettype wire

// *** verif/sfrel_pipe_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// one scalar lane per call; fields are inverted afterwards so stale values never look valid
module sfrel_pipe_model (
    input  wire logic          clk,
    output logic               res_valid,
    output logic               res_sign,
    output logic signed [11:0] res_exp,
    output logic        [47:0] res_sig,
    output logic        [2:0]  res_pre_flags,
    output logic               res_special,
    output logic        [31:0] res_special_val
);
    initial begin
        {res_valid, res_sign, res_exp, res_sig, res_pre_flags, res_special, res_special_val} = '0;
    end

    task automatic issue(input logic s, input logic signed [11:0] e, input logic [47:0] g,
                         input logic [2:0] p, input logic sp);
        @(posedge clk);
        res_valid <= 1'b1;
        {res_sign, res_exp, res_sig, res_pre_flags} <= {s, e, g, p};
        res_special <= sp;
        res_special_val <= g[31:0];
        @(posedge clk);
        res_valid <= 1'b0;
        res_special <= 1'b0;
        {res_sign, res_exp, res_sig, res_pre_flags} <= ~{s, e, g, p};
        res_special_val <= ~g[31:0];
    endtask : issue
endmodule : sfrel_pipe_model
`default_nettype wire

// *** verif/sfrel_top_props.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sfrel_defs.svh"

module sfrel_top_props (
    input wire logic        CLK,
    input wire logic        ARST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [31:0] OPND_A,
    input wire logic [31:0] OPND_A_DAZ,
    input wire logic        RES_VALID,
    input wire logic        RESULT_VALID,
    input wire logic [31:0] RESULT,
    input wire logic        RESULT_WE,
    input wire logic [5:0]  RESULT_FLAGS,
    input wire logic        EXC_TRAP,
    input wire logic [7:0]  EXC_VECTOR
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    a_result_two_late: assert property (RES_VALID |-> ##2 RESULT_VALID)
        else $error("result not two cycles after request");
    a_trap_vector: assert property (EXC_TRAP |-> RESULT_VALID && EXC_VECTOR == `SFREL_TRAP_VEC)
        else $error("trap without vector");
    a_vector_idle: assert property (!EXC_TRAP |-> EXC_VECTOR == 8'h00)
        else $error("vector without trap");
    a_trap_no_write: assert property (EXC_TRAP |-> !RESULT_WE)
        else $error("destination written on trap");
    a_ovf_masked_res: assert property (RESULT_VALID && !EXC_TRAP && RESULT_FLAGS[3] |->
        RESULT_FLAGS[5] && RESULT[30:0] inside {`SFREL_MAG_MAXF, `SFREL_MAG_INF})
        else $error("masked overflow result or flags wrong");
    a_unf_masked_inx: assert property (RESULT_VALID && !EXC_TRAP && RESULT_FLAGS[4] |-> RESULT_FLAGS[5])
        else $error("masked underflow without inexact");
    a_daz_normal: assert property (OPND_A[30:23] != 8'h00 |=> OPND_A_DAZ == $past(OPND_A))
        else $error("normal operand altered");
    a_result_quiet: assert property (!RESULT_VALID |-> RESULT == 32'h0 && !RESULT_WE && !EXC_TRAP)
        else $error("result outputs active while not valid");
    a_ready_setup: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
        else $error("ready not one cycle after setup");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
endmodule : sfrel_top_props

bind sfrel_top sfrel_top_props i_sfrel_top_props (
    .CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .OPND_A(OPND_A), .OPND_A_DAZ(OPND_A_DAZ), .RES_VALID(RES_VALID),
    .RESULT_VALID(RESULT_VALID), .RESULT(RESULT), .RESULT_WE(RESULT_WE),
    .RESULT_FLAGS(RESULT_FLAGS), .EXC_TRAP(EXC_TRAP), .EXC_VECTOR(EXC_VECTOR)
);
`default_nettype wire

// *** verif/sfrel_top_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sfrel_defs.svh"

module sfrel_top_test;
    logic               CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic        [11:0] PADDR;
    logic        [31:0] PWDATA, PRDATA, OPND_A, OPND_B, OPND_A_DAZ, OPND_B_DAZ, RES_SPECIAL_VAL, RESULT;
    logic               RES_VALID, RES_SIGN, RES_SPECIAL, RESULT_VALID, RESULT_WE, EXC_TRAP;
    logic signed [11:0] RES_EXP;
    logic        [47:0] RES_SIG;
    logic        [2:0]  RES_PRE_FLAGS;
    logic        [5:0]  RESULT_FLAGS;
    logic        [7:0]  EXC_VECTOR;
    int                 mismatches = 0;
    int                 comparisons = 0;
    localparam logic [47:0] SIG_ONE = 48'h800000000000;

    sfrel_top i_sfrel_top (
        .CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .OPND_A(OPND_A),
        .OPND_B(OPND_B), .OPND_A_DAZ(OPND_A_DAZ), .OPND_B_DAZ(OPND_B_DAZ), .RES_VALID(RES_VALID),
        .RES_SIGN(RES_SIGN), .RES_EXP(RES_EXP), .RES_SIG(RES_SIG), .RES_PRE_FLAGS(RES_PRE_FLAGS),
        .RES_SPECIAL(RES_SPECIAL), .RES_SPECIAL_VAL(RES_SPECIAL_VAL), .RESULT_VALID(RESULT_VALID),
        .RESULT(RESULT), .RESULT_WE(RESULT_WE), .RESULT_FLAGS(RESULT_FLAGS), .EXC_TRAP(EXC_TRAP),
        .EXC_VECTOR(EXC_VECTOR)
    );

    sfrel_pipe_model i_sfrel_pipe_model (
        .clk(CLK), .res_valid(RES_VALID), .res_sign(RES_SIGN), .res_exp(RES_EXP), .res_sig(RES_SIG),
        .res_pre_flags(RES_PRE_FLAGS), .res_special(RES_SPECIAL), .res_special_val(RES_SPECIAL_VAL)
    );

    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // request held until ready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge CLK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, w, a, d};
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 8);
        r = PRDATA;
        e = PSLVERR;
        {PSEL, PENABLE} <= 2'h0;
        if (PREADY !== 1'b1) begin
            mismatches++;
            test_done();
        end
    endtask : apb

    task automatic wr(input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, `SFREL_OFS_CTRL, d, r, e);
    endtask : wr

    // xf: bit 6 trap expected, bits 5:0 flags
    task automatic run(input logic s, input logic signed [11:0] e, input logic [47:0] g, input logic [2:0] p,
                       input logic sp, input logic [31:0] xr, input logic [6:0] xf);
        int n;
        i_sfrel_pipe_model.issue(s, e, g, p, sp);
        n = 0;
        do begin
            @(posedge CLK);
            #1;
            n++;
        end while (RESULT_VALID !== 1'b1 && n < 6);
        if (RESULT_VALID !== 1'b1) begin
            mismatches++;
            test_done();
        end
        chk("result", xr, RESULT);
        chk("trap_flags", {25'h0, xf}, {25'h0, EXC_TRAP, RESULT_FLAGS});
        chk("we_vector", {23'h0, !xf[6], xf[6] ? 8'h13 : 8'h00}, {23'h0, RESULT_WE, EXC_VECTOR});
    endtask : run

    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        apb(1'b0, `SFREL_OFS_CTRL, 32'h0, r, e);
        chk("ctrl_reset", 32'h00001F80, r);
        apb(1'b1, 12'h00C, 32'hFFFFFFFF, r, e);
        chk("unmapped_wr_err", 32'h1, {31'h0, e});
        apb(1'b0, 12'h00C, 32'h0, r, e);
        chk("unmapped_rd", {31'h0, 1'b1}, {r[30:0], e});
        apb(1'b1, `SFREL_OFS_CTRL, 32'hFFFFFFFF, r, e);
        apb(1'b0, `SFREL_OFS_CTRL, 32'h0, r, e);
        chk("ctrl_wmask", 32'h00007FFF, r);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_ovf_masked();
        logic [31:0] inf;
        logic [31:0] mx;
        logic [31:0] x [4];
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 2; s++) begin
                wr({17'h0, 2'(m), 13'h1F80});
                inf = {s[0], 31'h7F800000};
                mx = {s[0], 31'h7F7FFFFF};
                x = '{inf, s[0] ? inf : mx, s[0] ? mx : inf, mx};
                run(s[0], 12'sh080, SIG_ONE, 3'h0, 1'b0, x[m], 7'h28);
            end
        end
        $display("t_ovf_masked done");
    endtask : t_ovf_masked

    task automatic t_trap_scaled();
        wr(32'h00001B80);
        run(1'b0, 12'sh080, SIG_ONE, 3'h0, 1'b0, 32'h1F800000, 7'h48);
        run(1'b1, 12'sh080, SIG_ONE | 48'h1, 3'h0, 1'b0, 32'h9F800000, 7'h68);
        wr(32'h00001F80);
        run(1'b0, 12'shF81, SIG_ONE, 3'h0, 1'b0, 32'h00400000, 7'h00);
        run(1'b0, 12'shF81, 48'h8000017FFFFF, 3'h0, 1'b0, 32'h00400001, 7'h30);
        wr(32'h00001780);
        run(1'b1, 12'shF7E, SIG_ONE, 3'h0, 1'b0, 32'hDE800000, 7'h50);
        $display("t_trap_scaled done");
    endtask : t_trap_scaled

    task automatic t_inexact();
        logic [31:0] r;
        logic        e;
        wr(32'h00001F80);
        run(1'b0, 12'sh000, 48'h800001800000, 3'h0, 1'b0, 32'h3F800002, 7'h20);
        run(1'b0, 12'sh000, 48'h800000800000, 3'h0, 1'b0, 32'h3F800000, 7'h20);
        run(1'b0, 12'sh000, 48'hFFFFFF800000, 3'h0, 1'b0, 32'h40000000, 7'h20);
        wr(32'h00005F80);
        run(1'b0, 12'sh000, 48'h800000000001, 3'h0, 1'b0, 32'h3F800001, 7'h20);
        wr(32'h00003F80);
        run(1'b1, 12'sh000, 48'h800000000001, 3'h0, 1'b0, 32'hBF800001, 7'h20);
        wr(32'h00000F80);
        run(1'b0, 12'sh000, 48'h800001800000, 3'h0, 1'b0, 32'h3F800002, 7'h60);
        run(1'b1, 12'sh080, SIG_ONE, 3'h0, 1'b0, 32'hFF800000, 7'h68);
        apb(1'b0, `SFREL_OFS_STAT, 32'h0, r, e);
        chk("stat_last", 32'h00000068, r);
        apb(1'b1, `SFREL_OFS_LAST, 32'hFFFFFFFF, r, e);
        chk("last_ro_err", 32'h0, {31'h0, e});
        apb(1'b0, `SFREL_OFS_LAST, 32'h0, r, e);
        chk("last_result", 32'hFF800000, r);
        apb(1'b0, `SFREL_OFS_CTRL, 32'h0, r, e);
        chk("ctrl_sticky", 32'h00000FA8, r);
        $display("t_inexact done");
    endtask : t_inexact

    task automatic t_pre();
        wr(32'h00001F00);
        run(1'b0, 12'sh080, SIG_ONE, 3'h1, 1'b0, 32'h0, 7'h41);
        wr(32'h00001F80);
        run(1'b0, 12'sh000, SIG_ONE, 3'h4, 1'b0, 32'h3F800000, 7'h04);
        run(1'b0, 12'sh080, 48'h00007FC00000, 3'h0, 1'b1, 32'h7FC00000, 7'h00);
        $display("t_pre done");
    endtask : t_pre

    task automatic t_daz();
        wr(32'h00001FC0);
        @(posedge CLK);
        OPND_A <= 32'h80000123;
        OPND_B <= 32'h00000001;
        @(posedge CLK);
        OPND_A <= 32'h3F800000;
        #1;
        chk("opnd_a_daz", 32'h80000000, OPND_A_DAZ);
        chk("opnd_b_daz", 32'h00000000, OPND_B_DAZ);
        wr(32'h00001F80);
        @(posedge CLK);
        #1;
        chk("opnd_b_kept", 32'h00000001, OPND_B_DAZ);
        $display("t_daz done");
    endtask : t_daz

    initial begin
        ARST_N = 1'b0;
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        OPND_A = 32'h0;
        OPND_B = 32'h0;
        repeat (4) @(posedge CLK);
        ARST_N <= 1'b1;
        t_regs();
        t_ovf_masked();
        t_trap_scaled();
        t_inexact();
        t_pre();
        t_daz();
        test_done();
    end
endmodule : sfrel_top_test
`default_nettype wire
